// ### design/tafr_pkg.sv
`default_nettype none
package tafr_pkg;

  // interrupt codes
  localparam logic [7:0] CODE_RESET     = 8'h01;
  localparam logic [7:0] CODE_PARITY    = 8'h24;
  localparam logic [7:0] CODE_TIMEOUT   = 8'h2C;
  localparam logic [7:0] CODE_SELECTED  = 8'h64;

  // sequence steps
  localparam logic [7:0] STEP_NONE      = 8'h00;
  localparam logic [7:0] STEP_MSGOUT    = 8'h81;
  localparam logic [7:0] STEP_ID_MSG    = 8'h82;
  localparam logic [7:0] STEP_ID_CMD    = 8'h92;
  localparam logic [7:0] STEP_ID_CMD_AT = 8'h93;
  localparam logic [7:0] STEP_CMD       = 8'hB1;
  localparam logic [7:0] STEP_CMD_AT    = 8'hB2;

  // phase-assignment setting encoding
  localparam logic [1:0] ASSIGN_NONE    = 2'h0;
  localparam logic [1:0] ASSIGN_MSG     = 2'h1;
  localparam logic [1:0] ASSIGN_MSG_CMD = 2'h2;

  // report queue depth
  localparam int unsigned QDEPTH = 4;
  localparam int unsigned QPTRW  = 2;

  typedef enum logic [2:0]
  {
    PH_IDLE       = 3'b000,
    PH_MSGOUT     = 3'b001,
    PH_ID_MSG     = 3'b010,
    PH_ID_CMD     = 3'b011,
    PH_ID_CMD_ATN = 3'b100,
    PH_CMD        = 3'b101,
    PH_CMD_ATN    = 3'b110
  } tafr_phase_type;

  typedef struct packed
  {
    logic [7:0] code;
    logic [7:0] step;
  } tafr_report_type;

  typedef struct packed
  {
    logic reset_cond;
    logic parity_err;
    logic req_ack_timeout;
  } tafr_fault_type;

endpackage
`default_nettype wire

// ### design/tafr_fault_report.sv
// Summary of operation
// - reset in one-CMD ATN message-out: step B2h
// - reset terminations report code 01h
// - message-out parity: 24h, step 81h/93h
// - parity in message/CMD after Identify: 82h/92h
// - command-phase parity after selection: 24h
// - timeout after Identify: 2Ch, step 82h/92h
// - ATN message-out timeout: 2Ch, 93h/B2h
// - command-phase timeout after selection: 2Ch
// - late selection: 64h first, then outcome
// - busy selected: outcome first, then 64h
// - immediate cases end one cycle after detection
// - command cases need message-or-command assignment
// - one-CMD ATN cases need automatic receive
`default_nettype none
module tafr_fault_report
(
  // clock and reset
  input  wire logic                      mclk,
  input  wire logic                      rst_n,
  // sequencer state
  input  wire tafr_pkg::tafr_phase_type  phase,
  input  wire tafr_pkg::tafr_fault_type  fault,
  input  wire logic [1:0]                phase_assign,
  input  wire logic                      auto_receive,
  // selection events
  input  wire logic                      sel_after_lost_arb,
  input  wire logic                      cmd_while_selected,
  input  wire logic                      op_done,
  input  wire tafr_pkg::tafr_report_type op_result,
  // host side
  input  wire logic                      host_read,
  output tafr_pkg::tafr_report_type      report,
  output logic                           report_valid,
  output logic                           seq_abort,
  output logic                           queue_full
);

  // ************************************************************
  // fault classification
  // ************************************************************
  function automatic logic [7:0] step_of(input tafr_pkg::tafr_phase_type ph);
    unique case (ph)
      tafr_pkg::PH_IDLE:       step_of = tafr_pkg::STEP_NONE;
      tafr_pkg::PH_MSGOUT:     step_of = tafr_pkg::STEP_MSGOUT;
      tafr_pkg::PH_ID_MSG:     step_of = tafr_pkg::STEP_ID_MSG;
      tafr_pkg::PH_ID_CMD:     step_of = tafr_pkg::STEP_ID_CMD;
      tafr_pkg::PH_ID_CMD_ATN: step_of = tafr_pkg::STEP_ID_CMD_AT;
      tafr_pkg::PH_CMD:        step_of = tafr_pkg::STEP_CMD;
      tafr_pkg::PH_CMD_ATN:    step_of = tafr_pkg::STEP_CMD_AT;
      default:                 step_of = tafr_pkg::STEP_NONE;
    endcase
  endfunction

  logic cmd_ok;
  logic atn_ok;
  logic phase_ok;
  logic fault_hit;
  tafr_pkg::tafr_report_type fault_rep;

  always_comb
  begin
    cmd_ok = (phase_assign == tafr_pkg::ASSIGN_MSG) || (phase_assign == tafr_pkg::ASSIGN_MSG_CMD);
    atn_ok = cmd_ok && auto_receive;
    phase_ok = 1'b1;
    if (phase == tafr_pkg::PH_CMD)
    begin
      phase_ok = cmd_ok;
    end
    if (phase == tafr_pkg::PH_CMD_ATN)
    begin
      phase_ok = atn_ok;
    end
    fault_hit = 1'b0;
    fault_rep.code = tafr_pkg::CODE_RESET;
    fault_rep.step = step_of(phase);
    // reset outranks parity, parity outranks timeout
    if (fault.reset_cond)
    begin
      fault_hit = phase_ok;
      fault_rep.code = tafr_pkg::CODE_RESET;
    end
    else if (fault.parity_err && phase != tafr_pkg::PH_IDLE)
    begin
      fault_hit = phase_ok;
      fault_rep.code = tafr_pkg::CODE_PARITY;
    end
    else if (fault.req_ack_timeout && phase != tafr_pkg::PH_IDLE && phase != tafr_pkg::PH_MSGOUT)
    begin
      fault_hit = phase_ok;
      fault_rep.code = tafr_pkg::CODE_TIMEOUT;
    end
  end

  // ************************************************************
  // immediate termination
  // ************************************************************
  // abort registered, raised the cycle after detection so no further byte is handshaked
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      seq_abort <= 1'b0;
    end
    else
    begin
      seq_abort <= fault_hit;
    end
  end

  // ************************************************************
  // selection-event ordering
  // ************************************************************
  // a 64h owed after the running operation finishes
  // a command that meets the result in one cycle is served at once
  logic pend_sel_reg;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pend_sel_reg <= 1'b0;
    end
    else if ((op_done || fault_hit) && !sel_after_lost_arb)
    begin
      pend_sel_reg <= 1'b0;
    end
    else if (cmd_while_selected)
    begin
      pend_sel_reg <= 1'b1;
    end
  end

  // ************************************************************
  // report queue
  // ************************************************************
  // up to two pushes per cycle: a selection pair must stay ordered
  tafr_pkg::tafr_report_type q_mem [tafr_pkg::QDEPTH];
  logic [tafr_pkg::QPTRW-1:0] wr_ptr_reg;
  logic [tafr_pkg::QPTRW-1:0] rd_ptr_reg;
  logic [tafr_pkg::QPTRW:0]   count_reg;
  tafr_pkg::tafr_report_type push_a;
  tafr_pkg::tafr_report_type push_b;
  logic [1:0] n_push;
  logic       pop;
  tafr_pkg::tafr_report_type sel_rep;
  tafr_pkg::tafr_report_type done_rep;
  logic       done_any;

  always_comb
  begin
    sel_rep.code = tafr_pkg::CODE_SELECTED;
    sel_rep.step = tafr_pkg::STEP_NONE;
    done_any = fault_hit || op_done;
    done_rep = fault_hit ? fault_rep : op_result;
    push_a = sel_rep;
    push_b = sel_rep;
    n_push = 2'd0;
    if (sel_after_lost_arb)
    begin
      push_a = sel_rep;
      push_b = done_rep;
      n_push = done_any ? 2'd2 : 2'd1;
    end
    else if (done_any)
    begin
      push_a = done_rep;
      push_b = sel_rep;
      n_push = (pend_sel_reg || cmd_while_selected) ? 2'd2 : 2'd1;
    end
  end

  assign pop = host_read && (count_reg != '0);

  // a push that would overflow is dropped; queue_full warns ahead of it
  logic [tafr_pkg::QPTRW:0] room;
  logic [1:0] n_acc;

  always_comb
  begin
    room = (tafr_pkg::QPTRW+1)'(tafr_pkg::QDEPTH) - count_reg + (pop ? 1'b1 : 1'b0);
    n_acc = n_push;
    if ((tafr_pkg::QPTRW+1)'(n_push) > room)
    begin
      n_acc = room[1:0];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (n_acc != 2'd0)
    begin
      q_mem[wr_ptr_reg] <= push_a;
    end
    if (n_acc == 2'd2)
    begin
      q_mem[wr_ptr_reg + 1'b1] <= push_b;
    end
  end

  // ************************************************************
  // queue pointers
  // ************************************************************
  // shared by the counter and the head flags
  logic [tafr_pkg::QPTRW:0] count_next;

  always_comb
  begin
    count_next = count_reg + (tafr_pkg::QPTRW+1)'(n_acc) - (pop ? 1'b1 : 1'b0);
  end

  // pointers wrap on their own because the depth is a power of two
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_reg <= '0;
    end
    else
    begin
      wr_ptr_reg <= wr_ptr_reg + n_acc[tafr_pkg::QPTRW-1:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_ptr_reg <= '0;
    end
    else
    begin
      rd_ptr_reg <= rd_ptr_reg + (pop ? 1'b1 : 1'b0);
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_reg <= '0;
    end
    else
    begin
      count_reg <= count_next;
    end
  end

  // ************************************************************
  // host-visible head
  // ************************************************************
  // head is registered so it stays put until the host reads it
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      report_valid <= 1'b0;
    end
    else
    begin
      report_valid <= (count_next != '0);
    end
  end

  // warns at three entries so a producer can back off before a drop
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      queue_full <= 1'b0;
    end
    else
    begin
      queue_full <= (count_next >= (tafr_pkg::QPTRW+1)'(tafr_pkg::QDEPTH - 1));
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      report <= '0;
    end
    else if (count_reg == '0 || pop)
    begin
      if (count_reg == '0 || (count_reg == 1 && pop))
      begin
        report <= push_a;
      end
      else
      begin
        report <= q_mem[rd_ptr_reg + 1'b1];
      end
    end
  end

endmodule
`default_nettype wire

// ### test/tafr_checker.sv
`default_nettype none
module tafr_checker
(
  // clock and reset
  input wire logic                      mclk,
  input wire logic                      rst_n,
  // sequencer and events
  input wire tafr_pkg::tafr_phase_type  phase,
  input wire tafr_pkg::tafr_fault_type  fault,
  input wire logic [1:0]                phase_assign,
  input wire logic                      auto_receive,
  input wire logic                      sel_after_lost_arb,
  input wire logic                      cmd_while_selected,
  input wire logic                      op_done,
  input wire tafr_pkg::tafr_report_type op_result,
  // host side
  input wire logic                      host_read,
  input wire tafr_pkg::tafr_report_type report,
  input wire logic                      report_valid,
  input wire logic                      seq_abort,
  input wire logic                      queue_full
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       ok;
  logic [7:0] stp;
  logic       quiet;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // *****
  // fault acceptance
  // *****
  always_comb
  begin
    ok = |fault && (phase != tafr_pkg::PH_IDLE || fault.reset_cond);
    if (phase == tafr_pkg::PH_MSGOUT && fault == 3'h1) ok = 1'b0;
    if (phase inside {tafr_pkg::PH_CMD, tafr_pkg::PH_CMD_ATN} && !(phase_assign inside {2'h1, 2'h2})) ok = 1'b0;
    if (phase == tafr_pkg::PH_CMD_ATN && !auto_receive) ok = 1'b0;
    case (phase)
      tafr_pkg::PH_MSGOUT:     stp = 8'h81;
      tafr_pkg::PH_ID_MSG:     stp = 8'h82;
      tafr_pkg::PH_ID_CMD:     stp = 8'h92;
      tafr_pkg::PH_ID_CMD_ATN: stp = 8'h93;
      tafr_pkg::PH_CMD:        stp = 8'hB1;
      tafr_pkg::PH_CMD_ATN:    stp = 8'hB2;
      default:                 stp = 8'h00;
    endcase
  end
  // head only shows the fault when nothing else is queued or pushed
  assign quiet = !report_valid && !op_done && !sel_after_lost_arb;
  abort_on_fault_a: assert property (ok |=> seq_abort) else $error("no abort after fault");
  no_false_abort_a: assert property (!ok |=> !seq_abort) else $error("abort without fault");
  reset_code_a: assert property (ok && quiet && fault.reset_cond |=> report.code == 8'h01) else $error("bad reset code");
  parity_code_a: assert property (ok && quiet && fault == 3'h2 |=> report.code == 8'h24) else $error("bad parity code");
  timeout_code_a: assert property (ok && quiet && fault == 3'h1 |=> report.code == 8'h2C) else $error("bad timeout code");
  step_named_a: assert property (ok && quiet |=> report_valid && report.step == $past(stp)) else $error("bad step");
  report_hold_a: assert property (report_valid && !host_read |=> report_valid && $stable(report)) else $error("head moved");
  sel_first_a: assert property (sel_after_lost_arb && !report_valid && !ok |=> report == 16'h6400) else $error("64h late");
  fault_seen_c: cover property (ok ##1 seq_abort);
  sel_seen_c: cover property (sel_after_lost_arb && op_done);
  full_seen_c: cover property (queue_full);
endmodule
bind tafr_fault_report tafr_checker u_chk
(
  .mclk(mclk), .rst_n(rst_n), .phase(phase), .fault(fault), .phase_assign(phase_assign),
  .auto_receive(auto_receive), .sel_after_lost_arb(sel_after_lost_arb), .cmd_while_selected(cmd_while_selected),
  .op_done(op_done), .op_result(op_result), .host_read(host_read), .report(report),
  .report_valid(report_valid), .seq_abort(seq_abort), .queue_full(queue_full)
);
`default_nettype wire

// ### test/tafr_initiator_model.sv
`default_nettype none
module tafr_initiator_model
(
  // clock
  input  wire logic                     mclk,
  // post-selection bus state
  output var tafr_pkg::tafr_phase_type  phase,
  output var tafr_pkg::tafr_fault_type  fault
);
  timeunit 1ns;
  timeprecision 1ps;
  initial phase = tafr_pkg::PH_IDLE;
  initial fault = 3'h0;
  // *****
  // one faulty transfer
  // *****
  // fault lasts one cycle, else the block reports it every cycle
  task automatic hit(input tafr_pkg::tafr_phase_type p, input logic [2:0] f);
    @(posedge mclk);
    phase <= p;
    fault <= f;
    @(posedge mclk);
    phase <= tafr_pkg::PH_IDLE;
    fault <= 3'h0;
  endtask
endmodule
`default_nettype wire

// ### test/tafr_fault_report_tb.sv
`default_nettype none
module tafr_fault_report_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, rst_n = 0, auto_receive = 1, sel = 0, cmd = 0, op_done = 0, host_read = 0;
  logic [1:0] phase_assign = 2'h1;
  logic [15:0] op_result = 16'h0000;
  tafr_pkg::tafr_phase_type phase;
  tafr_pkg::tafr_fault_type fault;
  tafr_pkg::tafr_report_type report;
  logic report_valid, seq_abort, queue_full;
  int n_errors = 0, cmp_count = 0;
  always #20 mclk = ~mclk;
  tafr_initiator_model ini (.mclk(mclk), .phase(phase), .fault(fault));
  tafr_fault_report uut (.mclk(mclk), .rst_n(rst_n), .phase(phase), .fault(fault), .phase_assign(phase_assign),
    .auto_receive(auto_receive), .sel_after_lost_arb(sel), .cmd_while_selected(cmd), .op_done(op_done),
    .op_result(op_result), .host_read(host_read), .report(report), .report_valid(report_valid),
    .seq_abort(seq_abort), .queue_full(queue_full));
  // *****
  // shared tasks
  // *****
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic pop(input logic [15:0] e);
    int n;
    n = 0;
    while (report_valid !== 1'b1 && n < 20)
    begin
      @(posedge mclk);
      #1 n++;
    end
    if (report_valid !== 1'b1)
    begin
      n_errors++;
      conclude();
    end
    check(report, e);
    @(posedge mclk) host_read <= 1'b1;
    @(posedge mclk) host_read <= 1'b0;
    #1;
  endtask
  task automatic flt(input tafr_pkg::tafr_phase_type p, input logic [2:0] f, input logic [15:0] e);
    ini.hit(p, f);
    #1 check({15'h0, seq_abort}, {15'h0, e != 16'h0000});
    if (e != 16'h0000) pop(e);
    else check({15'h0, report_valid}, 16'h0000);
  endtask
  // *****
  // scenarios
  // *****
  task automatic t_faults();
    flt(tafr_pkg::PH_CMD_ATN, 3'h4, 16'h01B2);
    flt(tafr_pkg::PH_ID_MSG, 3'h7, 16'h0182);
    flt(tafr_pkg::PH_IDLE, 3'h4, 16'h0100);
    flt(tafr_pkg::PH_MSGOUT, 3'h2, 16'h2481);
    flt(tafr_pkg::PH_ID_CMD_ATN, 3'h2, 16'h2493);
    flt(tafr_pkg::PH_ID_MSG, 3'h2, 16'h2482);
    flt(tafr_pkg::PH_ID_CMD, 3'h2, 16'h2492);
    flt(tafr_pkg::PH_CMD, 3'h2, 16'h24B1);
    flt(tafr_pkg::PH_ID_MSG, 3'h1, 16'h2C82);
    flt(tafr_pkg::PH_ID_CMD, 3'h1, 16'h2C92);
    flt(tafr_pkg::PH_ID_CMD_ATN, 3'h1, 16'h2C93);
    flt(tafr_pkg::PH_CMD_ATN, 3'h1, 16'h2CB2);
    flt(tafr_pkg::PH_MSGOUT, 3'h1, 16'h0000);
    flt(tafr_pkg::PH_CMD, 3'h1, 16'h2CB1);
    $display("test done: fault codes");
  endtask
  task automatic t_refuse();
    @(posedge mclk) phase_assign <= 2'h0;
    flt(tafr_pkg::PH_CMD, 3'h2, 16'h0000);
    @(posedge mclk) phase_assign <= 2'h2;
    flt(tafr_pkg::PH_CMD, 3'h1, 16'h2CB1);
    @(posedge mclk) auto_receive <= 1'b0;
    flt(tafr_pkg::PH_CMD_ATN, 3'h2, 16'h0000);
    @(posedge mclk) auto_receive <= 1'b1;
    $display("test done: refusals");
  endtask
  task automatic t_order();
    @(posedge mclk) sel <= 1'b1;
    op_done <= 1'b1;
    op_result <= 16'hA6B2;
    @(posedge mclk) sel <= 1'b0;
    op_done <= 1'b0;
    #1 pop(16'h6400);
    pop(16'hA6B2);
    @(posedge mclk) cmd <= 1'b1;
    @(posedge mclk) cmd <= 1'b0;
    op_done <= 1'b1;
    op_result <= 16'hA793;
    @(posedge mclk) op_done <= 1'b0;
    #1 pop(16'hA793);
    pop(16'h6400);
    $display("test done: selection order");
  endtask
  task automatic t_fill();
    for (int i = 0; i < 5; i++)
    begin
      @(posedge mclk) op_done <= 1'b1;
      op_result <= {8'hA0, 8'(i)};
    end
    @(posedge mclk) op_done <= 1'b0;
    repeat (3) @(posedge mclk);
    #1 check({15'h0, queue_full}, 16'h0001);
    for (int i = 0; i < 4; i++) pop({8'hA0, 8'(i)});
    check({15'h0, report_valid}, 16'h0000);
    $display("test done: queue fill");
  endtask
  initial
  begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_faults();
    t_refuse();
    t_order();
    t_fill();
    conclude();
  end
endmodule
`default_nettype wire
